//--- include/deser_pkg.sv
// constants, types and helpers for the 1:16 serial deserializer
// assumes a single pclk domain; pins arrive unsynchronised
//
// Operation
// - each sixteen serial bits are assembled into one 16-bit parallel word.
// - bits come from the internal oscillator in recovery mode or from an external bit clock in digital mode.
// - with the rate select high the reference passes a divide-by-four stage, otherwise it bypasses it.
// - the lock flag goes low when bit clock divided by 64 differs from the reference by over 1000 ppm.
// - the lock flag is high while locked and low while not.
// - the active-low signal flag goes low when transition density is too low or too high.
// - the bit clock samples the serial data and also drives the divide-by-sixteen chain.
// - the divide-by-sixteen chain is four cascaded divide-by-two stages, each output feeding the tree.
// - the tree captures data on both edges of the half-rate stage output.
// - the sixteenth-rate clock drives the main word clock and a phase stage for the second word clock.
// - two word clocks, one fixed and one phase adjustable, come out beside the sixteen data bits.
// - phase selects hi/lo give 270 deg at 00, 180 at 01, 90 at 10 and 0 at 11.
// - a bit order select chooses whether the first serial bit lands on the lowest or highest output bit.
// - order 0 puts the first bit on bit fifteen, order 1 puts it on bit zero.
package deser_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned STG_W = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CTRL_W = 5;
  localparam int unsigned IRQ_W = 3;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFF = 8'h0C;
  localparam logic [ADDR_W-1:0] WORD_OFF = 8'h10;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_REFSEL_BIT = 1;
  localparam int CTRL_PH_LO_BIT = 2;
  localparam int CTRL_PH_HI_BIT = 3;
  localparam int CTRL_ORDER_BIT = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam int IRQ_LOL_BIT = 0;
  localparam int IRQ_LOS_BIT = 1;
  localparam int IRQ_WORD_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
  localparam int PIN_DATA = 0;
  localparam int PIN_ECLK = 1;
  localparam int PIN_REF = 2;
  localparam logic [1:0] REF_DIV_LAST = 2'h3;
  localparam int unsigned REF_WIN_DEF = 1024;
  localparam int unsigned REF_RATIO = 64;
  localparam int unsigned TOL_PPM = 1000;
  localparam int unsigned LOS_WIN = 64;
  localparam int unsigned LOS_MIN = 4;
  localparam int unsigned LOS_MAX = 60;
  localparam logic [1:0] PH_270 = 2'h0;
  localparam logic [1:0] PH_180 = 2'h1;
  localparam logic [1:0] PH_90 = 2'h2;
  localparam logic [1:0] PH_0 = 2'h3;
  localparam logic [STG_W-1:0] DLY_0 = 4'h0;
  localparam logic [STG_W-1:0] DLY_90 = 4'h4;
  localparam logic [STG_W-1:0] DLY_180 = 4'h8;
  localparam logic [STG_W-1:0] DLY_270 = 4'hC;

  typedef enum logic [1:0] {APB_IDLE = 2'b01, APB_ACK = 2'b10} apb_state_t;

  function automatic logic [STG_W-1:0] phase_delay(input logic [1:0] sel);
    case (sel)
      PH_270: phase_delay = DLY_270;
      PH_180: phase_delay = DLY_180;
      PH_90: phase_delay = DLY_90;
      default: phase_delay = DLY_0;
    endcase
  endfunction

  function automatic logic [WORD_W-1:0] bit_rev(input logic [WORD_W-1:0] w);
    for (int i = 0; i < WORD_W; i++) begin
      bit_rev[i] = w[WORD_W-1-i];
    end
  endfunction

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == CTRL_OFF) || (a == STAT_OFF) || (a == IRQ_STAT_OFF) ||
               (a == IRQ_MASK_OFF) || (a == WORD_OFF);
  endfunction
endpackage

//--- include/bit_stream_if.sv
// bit and reference strobes shared by the divider and the monitor
// assumes bit_stb and ref_stb are single-cycle strobes on pclk; bit_val is a level
`timescale 1ns/1ps
interface bit_stream_if;
  logic bit_stb;
  logic bit_val;
  logic ref_stb;
  modport src (output bit_stb, output bit_val, output ref_stb);
  modport div (input bit_stb);
  modport mon (input bit_stb, input bit_val, input ref_stb);
endinterface

//--- verilog/deser_divider.sv
// divide-by-sixteen chain and word clock phase stage
// assumes bit strobes at the serial bit rate on pclk
`timescale 1ns/1ps
module deser_divider
  import deser_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  bit_stream_if.div bs,
  input wire logic [1:0] ph_sel,
  output logic [STG_W-1:0] stage,
  output logic word_clk_main,
  output logic word_clk_phase
);
  logic [STG_W-1:0] stage_r;
  logic [STG_W-1:0] stage_nxt;
  logic [STG_W-1:0] shifted;
  logic carry;

  ////////////////////////////////////////////////////////////
  always_comb begin
    carry = 1'b1;
    for (int k = 0; k < STG_W; k++) begin
      stage_nxt[k] = stage_r[k] ^ carry;
      carry = carry & stage_r[k];
    end
    shifted = stage_nxt - phase_delay(ph_sel);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_r <= '0;
      word_clk_main <= 1'b0;
      word_clk_phase <= 1'b0;
    end else if (ce && bs.bit_stb) begin
      stage_r <= stage_nxt;
      word_clk_main <= stage_nxt[STG_W-1];
      word_clk_phase <= shifted[STG_W-1];
    end
  end

  assign stage = stage_r;
endmodule // deser_divider

//--- verilog/deser_monitor.sv
// frequency lock and transition density monitors
// assumes bit and divided reference strobes on pclk
`timescale 1ns/1ps
module deser_monitor
  import deser_pkg::*;
#(
  parameter int unsigned REF_WIN = REF_WIN_DEF
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  bit_stream_if.mon bs,
  output logic lock_ok,
  output logic signal_ok
);
  localparam int unsigned EXPECT = REF_WIN * REF_RATIO;
  localparam int unsigned TOL = EXPECT * TOL_PPM / 1000000;
  localparam int unsigned BC_W = $clog2(EXPECT * 2);
  localparam int unsigned RC_W = $clog2(REF_WIN + 1);
  localparam logic [BC_W-1:0] LO = BC_W'(EXPECT - TOL);
  localparam logic [BC_W-1:0] HI = BC_W'(EXPECT + TOL);
  localparam logic [RC_W-1:0] REF_LAST = RC_W'(REF_WIN - 1);
  localparam logic [5:0] LOS_LAST = 6'(LOS_WIN - 1);
  localparam logic [6:0] TR_MIN = 7'(LOS_MIN);
  localparam logic [6:0] TR_MAX = 7'(LOS_MAX);

  logic [BC_W-1:0] bit_cnt_r;
  logic [BC_W-1:0] bit_sum;
  logic [RC_W-1:0] ref_cnt_r;
  logic [5:0] win_cnt_r;
  logic [6:0] tr_cnt_r;
  logic [6:0] tr_sum;
  logic prev_r;

  assign bit_sum = (&bit_cnt_r) ? bit_cnt_r : bit_cnt_r + BC_W'(bs.bit_stb);
  assign tr_sum = tr_cnt_r + 7'(bs.bit_val ^ prev_r);

  ////////////////////////////////////////////////////////////
  // window is counted in reference periods so the tolerance scales with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_r <= '0;
      ref_cnt_r <= '0;
      lock_ok <= 1'b0;
    end else if (ce) begin
      if (bs.ref_stb && ref_cnt_r == REF_LAST) begin
        lock_ok <= (bit_sum >= LO) && (bit_sum <= HI);
        bit_cnt_r <= '0;
        ref_cnt_r <= '0;
      end else begin
        bit_cnt_r <= bit_sum;
        if (bs.ref_stb) begin
          ref_cnt_r <= ref_cnt_r + RC_W'(1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_r <= '0;
      tr_cnt_r <= '0;
      prev_r <= 1'b0;
      signal_ok <= 1'b0;
    end else if (ce && bs.bit_stb) begin
      prev_r <= bs.bit_val;
      win_cnt_r <= win_cnt_r + 6'h01;
      if (win_cnt_r == LOS_LAST) begin
        signal_ok <= (tr_sum >= TR_MIN) && (tr_sum <= TR_MAX);
        tr_cnt_r <= '0;
      end else begin
        tr_cnt_r <= tr_sum;
      end
    end
  end
endmodule // deser_monitor

//--- verilog/deser_top.sv
// 1:16 deserializer top: pin sync, mode select, tree, apb and interrupt
// assumes pins are asynchronous to pclk; bit rate well below pclk/4 in digital mode
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module deser_top
  import deser_pkg::*;
#(
  parameter int unsigned REF_WIN = REF_WIN_DEF
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic serial_data_in,
  input wire logic ext_bit_clk_in,
  input wire logic reference_clock_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [WORD_W-1:0] parallel_data_out,
  output logic word_clk_main,
  output logic word_clk_phase,
  output logic loss_of_lock_n,
  output logic loss_of_signal_n,
  output logic irq
);
  logic [2:0] pins;
  logic [2:0] meta1_r;
  logic [2:0] meta2_r;
  logic [2:0] meta3_r;
  logic [2:0] filt_r;
  logic [2:0] filt_d_r;
  logic [2:0] agree;
  logic [2:0] rise;
  logic [1:0] ref_div_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] rep_r;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic [STG_W-1:0] stage;
  logic [WORD_W-3:0] asm_r;
  logic [WORD_W-1:0] word_w;
  logic [WORD_W-1:0] data_r;
  logic first_r;
  logic word_evt;
  logic lock_ok;
  logic signal_ok;
  logic lock_d_r;
  logic sig_d_r;
  logic irq_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_val;
  logic pready_r;
  logic pslverr_r;
  logic apb_done;
  logic wr_done;
  apb_state_t st_r;

  bit_stream_if bs ();

  ////////////////////////////////////////////////////////////
  // pin synchronisers: a level is accepted once stages two and three agree
  assign pins = {reference_clock_in, ext_bit_clk_in, serial_data_in};
  assign agree = ~(meta2_r ^ meta3_r);
  assign rise = filt_r & ~filt_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta1_r <= '0;
      meta2_r <= '0;
      meta3_r <= '0;
      filt_r <= '0;
      filt_d_r <= '0;
    end else if (ce) begin
      meta1_r <= pins;
      meta2_r <= meta1_r;
      meta3_r <= meta2_r;
      filt_r <= (agree & meta3_r) | (~agree & filt_r);
      filt_d_r <= filt_r;
    end
  end

  ////////////////////////////////////////////////////////////
  // bit clock source: pclk stands in for the internal oscillator
  assign bs.bit_stb = ce & (ctrl_r[CTRL_MODE_BIT] ? rise[PIN_ECLK] : 1'b1);
  assign bs.bit_val = filt_r[PIN_DATA];

  ////////////////////////////////////////////////////////////
  // reference pre-divider
  assign bs.ref_stb = ce & rise[PIN_REF] &
                      (!ctrl_r[CTRL_REFSEL_BIT] || ref_div_r == REF_DIV_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_div_r <= '0;
    end else if (ce && rise[PIN_REF] && ctrl_r[CTRL_REFSEL_BIT]) begin
      ref_div_r <= ref_div_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////
  deser_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .bs(bs.div),
    .ph_sel({ctrl_r[CTRL_PH_HI_BIT], ctrl_r[CTRL_PH_LO_BIT]}),
    .stage(stage),
    .word_clk_main(word_clk_main),
    .word_clk_phase(word_clk_phase)
  );

  deser_monitor #(
    .REF_WIN(REF_WIN)
  ) u_mon (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .bs(bs.mon),
    .lock_ok(lock_ok),
    .signal_ok(signal_ok)
  );

  ////////////////////////////////////////////////////////////
  // deserializer tree: the even bit is held on one half-rate edge,
  // the pair is pushed on the other; no framing, words follow the divider
  assign word_w = {asm_r, first_r, bs.bit_val};
  assign word_evt = bs.bit_stb && (&stage);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_r <= 1'b0;
      asm_r <= '0;
      data_r <= '0;
    end else if (bs.bit_stb) begin
      if (!stage[0]) begin
        first_r <= bs.bit_val;
      end else if (&stage[STG_W-1:1]) begin
        // order is sampled per word so a change never splits one
        data_r <= ctrl_r[CTRL_ORDER_BIT] ? bit_rev(word_w) : word_w;
      end else begin
        asm_r <= {asm_r[WORD_W-5:0], first_r, bs.bit_val};
      end
    end
  end

  assign parallel_data_out = data_r;

  ////////////////////////////////////////////////////////////
  // apb slave: one wait state, pready registered
  assign apb_done = (st_r == APB_ACK) && psel && penable;
  assign wr_done = apb_done && pwrite && !pslverr_r;

  always_comb begin
    case (paddr)
      CTRL_OFF: rd_val = 32'(ctrl_r);
      STAT_OFF: rd_val = 32'({signal_ok, lock_ok});
      IRQ_STAT_OFF: rd_val = 32'(irq_stat_r);
      IRQ_MASK_OFF: rd_val = 32'(irq_mask_r);
      WORD_OFF: rd_val = 32'(data_r);
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= APB_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      rep_r <= '0;
    end else if (ce) begin
      case (st_r)
        APB_IDLE: begin
          if (psel && penable) begin
            st_r <= APB_ACK;
            pready_r <= 1'b1;
            pslverr_r <= !addr_hit(paddr);
            prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
            rep_r <= (!pwrite && paddr == IRQ_STAT_OFF) ? irq_stat_r : IRQ_RST;
          end
        end
        APB_ACK: begin
          if (apb_done) begin
            st_r <= APB_IDLE;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            rep_r <= IRQ_RST;
          end
        end
        default: begin
          st_r <= APB_IDLE;
          pready_r <= 1'b0;
          pslverr_r <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      irq_mask_r <= IRQ_RST;
    end else if (ce && wr_done) begin
      if (paddr == CTRL_OFF) begin
        ctrl_r <= pwdata[CTRL_W-1:0];
      end
      if (paddr == IRQ_MASK_OFF) begin
        irq_mask_r <= pwdata[IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // interrupts: only bits actually returned by the read are cleared,
  // so an event landing during the access survives
  assign ev[IRQ_LOL_BIT] = lock_d_r & ~lock_ok;
  assign ev[IRQ_LOS_BIT] = sig_d_r & ~signal_ok;
  assign ev[IRQ_WORD_BIT] = word_evt;
  assign clr = (apb_done && !pwrite) ? rep_r : IRQ_RST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= IRQ_RST;
      lock_d_r <= 1'b0;
      sig_d_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (ce) begin
      lock_d_r <= lock_ok;
      sig_d_r <= signal_ok;
      irq_stat_r <= (irq_stat_r & ~clr) | ev;
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign loss_of_lock_n = lock_ok;
  assign loss_of_signal_n = signal_ok;
  assign irq = irq_r;
endmodule // deser_top

//--- bench/deser_top_monitor.sv
// checker for deser_top: word timing, word clock phase and flag relations
// assumes ce held high and ctrl changed only by apb writes
`timescale 1ns/1ps
module deser_top_monitor
  import deser_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ext_bit_clk_in,
  input wire logic serial_data_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [WORD_W-1:0] parallel_data_out,
  input wire logic word_clk_main,
  input wire logic word_clk_phase,
  input wire logic loss_of_lock_n,
  input wire logic loss_of_signal_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [CTRL_W-1:0] ctrl_r;
  logic [7:0] calm_r;
  logic [7:0] quiet_r;
  logic [7:0] idle_r;
  logic done, wr_ctrl, dig, settled;
  logic [1:0] ph;
  assign done = psel && penable && pready;
  assign wr_ctrl = done && pwrite && paddr == CTRL_OFF;
  assign dig = ctrl_r[CTRL_MODE_BIT];
  assign ph = {ctrl_r[CTRL_PH_HI_BIT], ctrl_r[CTRL_PH_LO_BIT]};
  assign settled = &calm_r;
  // counters saturate: only "long enough" matters, so they never wrap into a false start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      calm_r <= 8'h00;
      quiet_r <= 8'h00;
      idle_r <= 8'h00;
    end else begin
      ctrl_r <= wr_ctrl ? pwdata[CTRL_W-1:0] : ctrl_r;
      calm_r <= wr_ctrl ? 8'h00 : calm_r + {7'h00, ~settled};
      quiet_r <= $changed(serial_data_in) ? 8'h00 : quiet_r + {7'h00, ~&quiet_r};
      idle_r <= $changed(ext_bit_clk_in) ? 8'h00 : idle_r + {7'h00, ~&idle_r};
    end
  end
  ////////////////////////////////////////
  sequence s_rise;
    !dig && settled && $rose(word_clk_main);
  endsequence
  property p_word_hold;
    $changed(parallel_data_out) |=> $stable(parallel_data_out) [*8];
  endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("word changed twice within 8 bits");
  property p_word_low;
    $changed(parallel_data_out) |-> ##[0:1] !word_clk_main;
  endproperty
  a_word_low: assert property (p_word_low)
    else $error("word changed away from word clock fall");
  property p_main_half;
    s_rise |-> word_clk_main [*8] ##1 !word_clk_main;
  endproperty
  a_main_half: assert property (p_main_half)
    else $error("main word clock high not 8 bits");
  property p_ph_270;
    s_rise ##0 (ph == PH_270) |-> ##[11:14] $rose(word_clk_phase);
  endproperty
  a_ph_270: assert property (p_ph_270)
    else $error("phase clock not 12 bits late");
  property p_ph_180;
    s_rise ##0 (ph == PH_180) |-> ##[7:10] $rose(word_clk_phase);
  endproperty
  a_ph_180: assert property (p_ph_180)
    else $error("phase clock not 8 bits late");
  property p_ph_90;
    s_rise ##0 (ph == PH_90) |-> ##[3:6] $rose(word_clk_phase);
  endproperty
  a_ph_90: assert property (p_ph_90)
    else $error("phase clock not 4 bits late");
  property p_ph_0;
    s_rise ##0 (ph == PH_0) |-> ##[0:2] $rose(word_clk_phase);
  endproperty
  a_ph_0: assert property (p_ph_0)
    else $error("phase clock not aligned to main");
  property p_stat;
    done && !pwrite && paddr == STAT_OFF |-> prdata[1:0] == $past({loss_of_signal_n, loss_of_lock_n});
  endproperty
  a_stat: assert property (p_stat)
    else $error("status read disagrees with flags");
  property p_quiet;
    !dig && settled && &quiet_r |-> !loss_of_signal_n;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("signal flag high on a still line");
  property p_idle;
    dig && settled && &idle_r |-> $stable(parallel_data_out) && $stable(word_clk_main);
  endproperty
  a_idle: assert property (p_idle)
    else $error("word moved without bit clock");
  c_word: cover property ($changed(parallel_data_out));
  c_lock_lost: cover property ($fell(loss_of_lock_n));
  c_signal_lost: cover property ($fell(loss_of_signal_n));
endmodule // deser_top_monitor

bind deser_top deser_top_monitor deser_top_monitor_i (.pclk, .presetn, .ext_bit_clk_in, .serial_data_in,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .parallel_data_out, .word_clk_main,
  .word_clk_phase, .loss_of_lock_n, .loss_of_signal_n);

//--- bench/bit_src.sv
// serial source model: data pin, bit clock pin and reference clock pin
// assumes pclk stands in for the source's own timebase
`timescale 1ns/1ps
module bit_src (
  input wire logic pclk,
  output logic serial_data_in,
  output logic ext_bit_clk_in,
  output logic reference_clock_in
);
  int ref_half = 32;
  int dat_half = 4;
  int n = 0;
  initial begin
    serial_data_in = 1'h0;
    ext_bit_clk_in = 1'h0;
    reference_clock_in = 1'h0;
  end
  // reference runs free, as a crystal would; must stay above zero
  always begin
    repeat (ref_half) @(posedge pclk);
    reference_clock_in <= ~reference_clock_in;
  end
  // pattern mode; dat_half 0 hands the pin to send_bit
  always @(posedge pclk) begin
    if (dat_half != 0) begin
      n <= (n + 1) % dat_half;
      if (n % dat_half == dat_half - 1) serial_data_in <= ~serial_data_in;
    end
  end
  // data leads the bit clock edge and is flipped after its hold,
  // so a late sample can never see a stale bit
  task automatic send_bit(input logic b);
    @(posedge pclk);
    serial_data_in <= b;
    repeat (4) @(posedge pclk);
    ext_bit_clk_in <= 1'h1;
    repeat (4) @(posedge pclk);
    ext_bit_clk_in <= 1'h0;
    repeat (4) @(posedge pclk);
    serial_data_in <= ~b;
  endtask
endmodule // bit_src

//--- bench/deser_top_test.sv
// bench for deser_top: apb master, serial source model, self-checking sequence
// assumes deser_pkg compiled first and the checker bound by its own file
`timescale 1ns/1ps
module deser_top_test
  import deser_pkg::*;
;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata, m, p;
  logic pready, pslverr, rerr, irq, word_clk_main, word_clk_phase, loss_of_lock_n, loss_of_signal_n;
  logic serial_data_in, ext_bit_clk_in, reference_clock_in;
  logic [WORD_W-1:0] parallel_data_out, pat, rev;
  int fails = 0;
  int checks_done = 0;
  int los_half[4] = '{4, 1, 4, 0};
  int i, j, tr;
  always #20 pclk = ~pclk;
  // short lock window keeps the run brief; expectations scale with it
  deser_top #(.REF_WIN(16)) deser_top_i (.pclk, .presetn, .ce(1'h1), .serial_data_in, .ext_bit_clk_in,
    .reference_clock_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .parallel_data_out, .word_clk_main, .word_clk_phase, .loss_of_lock_n, .loss_of_signal_n, .irq);
  bit_src bit_src_i (.pclk, .serial_data_in, .ext_bit_clk_in, .reference_clock_in);
  ////////////////////////////////////////
  task automatic close_out;
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    chk(pready, 1'h1);
    if (k == 20) close_out();
  endtask
  task automatic wait_flag(input bit los, input logic lvl, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(negedge pclk);
      if ((los ? loss_of_signal_n : loss_of_lock_n) === lvl) break;
    end
    chk(los ? loss_of_signal_n : loss_of_lock_n, lvl);
    if (k == lim) close_out();
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, CTRL_OFF, 32'h0);
    chk(rdata, 32'h0);
    apb(1'h0, 8'h14, 32'h0);
    chk({rerr, rdata[30:0]}, 32'h80000000);
    wait_flag(0, 1'h1, 4000);
    apb(1'h0, STAT_OFF, 32'h0);
    chk(rdata[0], 1'h1);
    bit_src_i.ref_half = 8;
    apb(1'h1, CTRL_OFF, 32'(1 << CTRL_REFSEL_BIT));
    repeat (3000) @(negedge pclk);
    chk(loss_of_lock_n, 1'h1);
    apb(1'h0, IRQ_STAT_OFF, 32'h0);
    apb(1'h1, CTRL_OFF, 32'h0);
    wait_flag(0, 1'h0, 4000);
    repeat (4) @(negedge pclk);
    chk(irq, 1'h0);
    apb(1'h1, IRQ_MASK_OFF, 32'(1 << IRQ_LOL_BIT));
    repeat (3) @(negedge pclk);
    chk(irq, 1'h1);
    apb(1'h0, IRQ_STAT_OFF, 32'h0);
    chk(rdata[IRQ_LOL_BIT], 1'h1);
    repeat (3) @(negedge pclk);
    chk(irq, 1'h0);
    bit_src_i.ref_half = 32;
    for (i = 0; i < 4; i++) begin
      bit_src_i.dat_half = los_half[i];
      tr = los_half[i] != 0 ? 64 / los_half[i] : 0;
      wait_flag(1, tr >= LOS_MIN && tr <= LOS_MAX, 400);
    end
    apb(1'h0, IRQ_STAT_OFF, 32'h0);
    chk({rdata[IRQ_WORD_BIT], rdata[IRQ_LOS_BIT]}, 32'h3);
    for (i = 0; i < 4; i++) begin
      apb(1'h1, CTRL_OFF, 32'(i << CTRL_PH_LO_BIT));
      repeat (300) @(negedge pclk);
      for (j = 0; j < 32; j++) begin
        @(negedge pclk);
        m[j] = word_clk_main;
        p[j] = word_clk_phase;
      end
      chk(p[31:16], m[31-(3-i)*4 -: 16]);
    end
    bit_src_i.dat_half = 0;
    apb(1'h1, CTRL_OFF, 32'(1 << CTRL_MODE_BIT));
    // the last recovery strobe lands on the write edge; read the word clock after it settles
    @(negedge pclk);
    m[0] = 1'h0;
    for (i = 0; i < 40 && !(m[0] === 1'h1 && word_clk_main === 1'h0); i++) begin
      m[0] = word_clk_main;
      bit_src_i.send_bit(1'h0);
      repeat (4) @(negedge pclk);
    end
    chk(i < 40, 1'h1);
    if (i == 40) close_out();
    pat = 16'h8E31;
    for (j = 15; j >= 0; j--) bit_src_i.send_bit(pat[j]);
    repeat (4) @(negedge pclk);
    chk(parallel_data_out, pat);
    apb(1'h0, WORD_OFF, 32'h0);
    chk(rdata, {16'h0000, pat});
    apb(1'h1, CTRL_OFF, 32'((1 << CTRL_MODE_BIT) | (1 << CTRL_ORDER_BIT)));
    for (j = 15; j >= 0; j--) bit_src_i.send_bit(pat[j]);
    repeat (4) @(negedge pclk);
    for (j = 0; j < 16; j++) rev[j] = pat[15-j];
    chk(parallel_data_out, rev);
    repeat (300) @(negedge pclk);
    chk(parallel_data_out, rev);
    close_out();
  end
endmodule // deser_top_test
